// ---- src/cap_switch_defines.svh ----
// Timing counts and line-output encodings for the bulk capacitor sequencer.
`ifndef CAP_SWITCH_DEFINES_SVH
`define CAP_SWITCH_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define BROWNOUT_TIME_MS 500
`define BROWNOUT_CYCLES ((`BROWNOUT_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define SURGE_TIME_US 130
`define SURGE_CYCLES ((`SURGE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SETTLE_TIME_MS 20
`define SETTLE_CYCLES ((`SETTLE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`define LINE_MIRROR 2'h0
`define LINE_UV_INJECT 2'h1
`define LINE_OV_INJECT 2'h2

`endif

// ---- src/cap_switch_pkg.sv ----
// Types shared by the bulk capacitor sequencer.
package cap_switch_pkg;

    typedef enum logic [2:0]
    {
        ST_OFF = 3'h0,
        ST_SETTLE = 3'h1,
        ST_CHARGE = 3'h3,
        ST_RUN = 3'h2,
        ST_THERMAL = 3'h6,
        ST_PIN_FAULT = 3'h7
    } seq_state_t;

    typedef logic [1:0] line_mode_t;

endpackage

// ---- src/event_timer.sv ----
// Down-counting interval timer that restarts or clears on command.
`timescale 1ns/10ps

module event_timer #(
    parameter int WIDTH = 26
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic clear,
    input wire logic [WIDTH-1:0] load_value,
    output logic busy,
    output logic done
);

    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic done_ff;
    wire logic at_last = (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});

    // Clear beats start so that an ended condition never leaves a stale count.
    assign nxt_count = clear ? '0 :
                       start ? load_value :
                       (count_ff != '0) ? count_ff - 1'b1 : count_ff;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            done_ff <= at_last && !clear && !start;
        end
    end

    assign busy = (count_ff != '0);
    assign done = done_ff;

endmodule

// ---- src/bulk_cap_switch_sequencer.sv ----
// Steady-state switch control, fault handling and line signalling.
// Functional notes
// - Switch on while bus below upper threshold.
// - Switch off when bus reaches upper threshold.
// - Re-engage after lower threshold and equal voltages.
// - Engage decisions repeat freely every line cycle.
// - Trickle-charge within window while bus stays high.
// - Undervoltage for 500 ms restarts start-up.
// - Surge while on forces switch off 130 us.
// - Surges never reach the line output.
// - Over-temperature shuts down, injects overvoltage current.
// - Cooling below hysteresis restarts start-up.
// - Pin open/short injects overvoltage current while present.
// - Cleared pin fault restarts start-up.
// - Faults reported only through line output.
// - Line output mirrors top sense current normally.
// - Wait 20 ms after brown-in before sampling.
// - Start-up injects undervoltage current on line.
`timescale 1ns/10ps

`include "cap_switch_defines.svh"

module bulk_cap_switch_sequencer
    import cap_switch_pkg::*;
#(
    parameter int BROWNOUT_CYCLES = `BROWNOUT_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter int SURGE_CYCLES = `SURGE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_above_upper,
    input wire logic bus_below_lower,
    input wire logic caps_equal,
    input wire logic bus_below_uv,
    input wire logic brown_in,
    input wire logic charge_done,
    input wire logic below_trickle_window,
    input wire logic surge_detect,
    input wire logic over_temp,
    input wire logic temp_recovered,
    input wire logic pin_fault,
    output logic switch_on,
    output logic trickle_on,
    output logic charge_enable,
    output logic [1:0] line_mode
);

    localparam int TW = 26;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // All comparator and fault levels come from the analog side, so each
    // passes two flops before any decision looks at it.
    localparam int NIN = 11;
    logic [NIN-1:0] meta_ff;
    logic [NIN-1:0] sync_ff;
    wire logic [NIN-1:0] raw_in = {bus_above_upper, bus_below_lower,
        caps_equal, bus_below_uv, brown_in, charge_done,
        below_trickle_window, surge_detect, over_temp, temp_recovered,
        pin_fault};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    wire logic s_above = sync_ff[10];
    wire logic s_below_lower = sync_ff[9];
    wire logic s_equal = sync_ff[8];
    wire logic s_uv = sync_ff[7];
    wire logic s_brown_in = sync_ff[6];
    wire logic s_charged = sync_ff[5];
    wire logic s_trickle_low = sync_ff[4];
    wire logic s_surge = sync_ff[3];
    wire logic s_hot = sync_ff[2];
    wire logic s_cool = sync_ff[1];
    wire logic s_pin = sync_ff[0];

    // ------------------------------------------------------------------
    // Sequencer state and timers
    // ------------------------------------------------------------------
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic switch_ff;
    logic nxt_switch;
    logic trickle_ff;
    logic charge_ff;
    logic [1:0] line_ff;
    logic [1:0] nxt_line;
    logic bo_busy;
    logic bo_done;
    logic st_done;
    logic sg_busy;
    logic settle_armed_ff;

    wire logic in_run = (state_ff == ST_RUN);

    // Brown-out interval runs only while undervoltage persists in run.
    wire logic bo_start = in_run && s_uv && !bo_busy && !bo_done;
    wire logic bo_clear = !(in_run && s_uv);

    event_timer #(
        .WIDTH(TW)
    ) u_brownout (
        .clk(clk),
        .rst_n(rst_n),
        .start(bo_start),
        .clear(bo_clear),
        .load_value(TW'(BROWNOUT_CYCLES)),
        .busy(bo_busy),
        .done(bo_done)
    );

    // Settle wait after brown-in, shared timer form for start-up.
    wire logic st_start = (state_ff == ST_SETTLE) && !settle_armed_ff;
    wire logic st_clear = (state_ff != ST_SETTLE);

    event_timer #(
        .WIDTH(TW)
    ) u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .start(st_start),
        .clear(st_clear),
        .load_value(TW'(SETTLE_CYCLES)),
        .busy(),
        .done(st_done)
    );

    // A surge only counts while the switch is actually closed.
    wire logic sg_start = in_run && switch_ff && s_surge && !sg_busy;
    wire logic sg_clear = !in_run;

    event_timer #(
        .WIDTH(TW)
    ) u_surge (
        .clk(clk),
        .rst_n(rst_n),
        .start(sg_start),
        .clear(sg_clear),
        .load_value(TW'(SURGE_CYCLES)),
        .busy(sg_busy),
        .done()
    );

    wire logic surge_hold = sg_busy || sg_start;

    // ------------------------------------------------------------------
    // Next-state and output decode
    // ------------------------------------------------------------------
    // Faults take priority: thermal, then pin, then brown-out.
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF:
                if (s_brown_in)
                    nxt_state = ST_SETTLE;
            ST_SETTLE:
                if (st_done)
                    nxt_state = ST_CHARGE;
            ST_CHARGE:
                if (s_charged)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (bo_done)
                    nxt_state = ST_OFF;
            ST_THERMAL:
                if (s_cool && !s_hot)
                    nxt_state = ST_OFF;
            ST_PIN_FAULT:
                if (!s_pin)
                    nxt_state = ST_OFF;
            default:
                nxt_state = ST_OFF;
        endcase
        if (s_hot)
            nxt_state = ST_THERMAL;
        else if (s_pin && state_ff != ST_THERMAL)
            nxt_state = ST_PIN_FAULT;
    end

    // Hysteretic engage: off at the upper level, back on only once the bus
    // is under the lower level and the bottom sense shows equal voltages.
    // No cycle-count lockout, so this may toggle many times per line cycle.
    always_comb
    begin
        nxt_switch = switch_ff;
        if (!in_run || nxt_state != ST_RUN)
            nxt_switch = 1'b0;
        else if (surge_hold)
            nxt_switch = 1'b0;
        else if (s_above)
            nxt_switch = 1'b0;
        else if (!switch_ff && s_below_lower && s_equal)
            nxt_switch = 1'b1;
        else if (switch_ff)
            nxt_switch = 1'b1;
    end

    // Trickle charge only while the switch stays open above the upper level.
    wire logic nxt_trickle = in_run && !switch_ff && s_above &&
        s_trickle_low;

    // The line output carries start-up and fault states only; surges are
    // deliberately absent from this decode.
    always_comb
    begin
        nxt_line = `LINE_MIRROR;
        if (nxt_state == ST_THERMAL || nxt_state == ST_PIN_FAULT)
            nxt_line = `LINE_OV_INJECT;
        else if (nxt_state != ST_RUN)
            nxt_line = `LINE_UV_INJECT;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_OFF;
            switch_ff <= 1'b0;
            trickle_ff <= 1'b0;
            charge_ff <= 1'b0;
            line_ff <= `LINE_UV_INJECT;
            settle_armed_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            switch_ff <= nxt_switch;
            trickle_ff <= nxt_trickle;
            charge_ff <= (nxt_state == ST_CHARGE);
            line_ff <= nxt_line;
            settle_armed_ff <= (state_ff == ST_SETTLE);
        end
    end

    assign switch_on = switch_ff;
    assign trickle_on = trickle_ff;
    assign charge_enable = charge_ff;
    assign line_mode = line_ff;

endmodule

// ---- sim/line_partner.sv ----
// Far-side controller model that reads the line output.
`timescale 1ns/10ps
`include "cap_switch_defines.svh"

module line_partner (
    input wire logic [1:0] line_mode,
    output logic uv_seen,
    output logic ov_seen
);
    // Injected levels read as line faults; the mirror reads as healthy.
    assign uv_seen = line_mode == `LINE_UV_INJECT;
    assign ov_seen = line_mode == `LINE_OV_INJECT;
endmodule

// ---- sim/bulk_cap_switch_sequencer_chk.sv ----
// Concurrent checks on the sequencer's ports.
`timescale 1ns/10ps
`include "cap_switch_defines.svh"

module bulk_cap_switch_sequencer_chk #(
    parameter int BROWNOUT_CYCLES = 200,
    parameter int SETTLE_CYCLES = 50,
    parameter int SURGE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_above_upper,
    input wire logic surge_detect,
    input wire logic over_temp,
    input wire logic pin_fault,
    input wire logic switch_on,
    input wire logic trickle_on,
    input wire logic charge_enable,
    input wire logic [1:0] line_mode
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Inputs pass a two-flop sync, so five samples cover the latency.
    sequence s_surge_hit;
        switch_on && $rose(surge_detect);
    endsequence
    sequence s_quiet_run;
        line_mode == `LINE_MIRROR && !over_temp && !pin_fault;
    endsequence

    property p_surge_off;
        s_surge_hit |-> ##[1:4] !switch_on;
    endproperty
    property p_surge_quiet;
        s_surge_hit ##0 s_quiet_run |=> (line_mode == `LINE_MIRROR)[*3];
    endproperty
    property p_upper_off;
        bus_above_upper[*5] |-> !switch_on;
    endproperty
    property p_thermal;
        over_temp[*5] |-> line_mode == `LINE_OV_INJECT;
    endproperty
    property p_pin;
        pin_fault[*5] |-> line_mode == `LINE_OV_INJECT;
    endproperty
    property p_ov_safe;
        line_mode == `LINE_OV_INJECT |-> !switch_on && !charge_enable;
    endproperty
    property p_uv_safe;
        line_mode == `LINE_UV_INJECT |-> !switch_on;
    endproperty
    property p_trickle;
        trickle_on |-> !switch_on;
    endproperty

    a_surge_off: assert property (p_surge_off)
        else $error("switch held on after surge");
    a_surge_quiet: assert property (p_surge_quiet)
        else $error("surge changed line output");
    a_upper_off: assert property (p_upper_off)
        else $error("switch on above upper threshold");
    a_thermal: assert property (p_thermal)
        else $error("no injection on over-temperature");
    a_pin: assert property (p_pin)
        else $error("no injection on pin fault");
    a_ov_safe: assert property (p_ov_safe)
        else $error("switch active during fault");
    a_uv_safe: assert property (p_uv_safe)
        else $error("switch on during start-up");
    a_trickle: assert property (p_trickle)
        else $error("trickle with switch on");
endmodule

bind bulk_cap_switch_sequencer bulk_cap_switch_sequencer_chk #(
    .BROWNOUT_CYCLES(BROWNOUT_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .SURGE_CYCLES(SURGE_CYCLES)
) i_chk (.clk, .rst_n, .bus_above_upper, .surge_detect, .over_temp,
    .pin_fault, .switch_on, .trickle_on, .charge_enable, .line_mode);

// ---- sim/bulk_cap_switch_sequencer_test.sv ----
// Self-checking bench for the bulk capacitor switch sequencer.
`timescale 1ns/10ps

module bulk_cap_switch_sequencer_test;
    localparam int BO = 200;
    localparam int ST = 50;
    localparam int SG = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_above_upper, bus_below_lower, caps_equal, bus_below_uv;
    logic brown_in, charge_done, below_trickle_window, surge_detect;
    logic over_temp, temp_recovered, pin_fault, uv_seen, ov_seen;
    logic switch_on, trickle_on, charge_enable;
    logic [1:0] line_mode;
    wire logic [4:0] outs = {switch_on, trickle_on, charge_enable, line_mode};
    wire logic [4:0] seen = {3'h0, ov_seen, uv_seen};
    logic [7:0] lfsr_ff = 8'h0a;
    logic [4:0] exp_q[$];
    logic [4:0] exp_v;
    int num_errors = 0;
    int compares = 0;
    event chk_ev;

    // Half-period toggle gives the 100 MHz clock.
    always #5 clk = ~clk;

    bulk_cap_switch_sequencer #(
        .BROWNOUT_CYCLES(BO),
        .SETTLE_CYCLES(ST),
        .SURGE_CYCLES(SG)
    ) i_bulk_cap_switch_sequencer (
        .clk, .rst_n, .bus_above_upper, .bus_below_lower, .caps_equal,
        .bus_below_uv, .brown_in, .charge_done, .below_trickle_window,
        .surge_detect, .over_temp, .temp_recovered, .pin_fault,
        .switch_on, .trickle_on, .charge_enable, .line_mode
    );

    line_partner i_line_partner (.line_mode, .uv_seen, .ov_seen);

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Notes are {switch, trickle, charge, line mode}.
    task automatic expect_out(input logic [4:0] v);
        exp_q.push_back(v);
        ->chk_ev;
    endtask

    task automatic cmp(input logic [4:0] e, input logic [4:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    // Start-up walk; check windows sit well clear of the settle edge.
    task automatic to_run();
        brown_in = 1'b1;
        step(ST - 10);
        expect_out(5'h01);
        step(20);
        expect_out(5'h05);
        // Run entry needs the re-engage levels, or the switch stays open.
        {charge_done, bus_below_lower, caps_equal} = 3'b111;
        step(5);
        expect_out(5'h10);
        $display("start-up done");
    endtask

    task automatic complete_run();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Oldest note against the settled outputs and the partner's view.
    always @(chk_ev)
    begin
        exp_v = exp_q.pop_front();
        cmp(exp_v, outs);
        cmp({3'h0, exp_v[1:0] == 2'h2, exp_v[1:0] == 2'h1}, seen);
    end

    // Hang guard, sized well beyond the whole sequence.
    initial
    begin
        step(20000);
        num_errors++;
        complete_run();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        {bus_above_upper, bus_below_lower, caps_equal, bus_below_uv} = '0;
        {brown_in, charge_done, below_trickle_window, surge_detect} = '0;
        {over_temp, temp_recovered, pin_fault} = '0;
        step(6);
        rst_n = 1'b1;
        expect_out(5'h01);
        to_run();
        for (int i = 0; i < 6; i++)
        begin
            {bus_above_upper, bus_below_lower} = 2'b10;
            step(5);
            expect_out(5'h00);
            lfsr_ff = lfsr_next(lfsr_ff);
            bus_above_upper = 1'b0;
            {bus_below_lower, caps_equal} = lfsr_ff[1:0];
            step(5);
            expect_out({&lfsr_ff[1:0], 4'h0});
            {bus_below_lower, caps_equal} = 2'b11;
            step(5);
            expect_out(5'h10);
        end
        $display("hysteresis done");
        {bus_above_upper, below_trickle_window} = 2'b11;
        step(5);
        expect_out(5'h08);
        below_trickle_window = 1'b0;
        step(5);
        expect_out(5'h00);
        bus_above_upper = 1'b0;
        step(5);
        surge_detect = 1'b1;
        step(2);
        surge_detect = 1'b0;
        step(2);
        expect_out(5'h00);
        step(SG - 8);
        expect_out(5'h00);
        step(14);
        expect_out(5'h10);
        $display("surge done");
        bus_below_uv = 1'b1;
        step(BO - 20);
        bus_below_uv = 1'b0;
        step(10);
        expect_out(5'h10);
        {brown_in, charge_done, bus_below_uv} = 3'b001;
        step(BO + 10);
        expect_out(5'h01);
        bus_below_uv = 1'b0;
        to_run();
        {brown_in, charge_done, over_temp} = 3'b001;
        step(5);
        expect_out(5'h02);
        over_temp = 1'b0;
        step(5);
        expect_out(5'h02);
        temp_recovered = 1'b1;
        step(5);
        expect_out(5'h01);
        temp_recovered = 1'b0;
        to_run();
        {brown_in, charge_done, pin_fault} = 3'b001;
        step(25);
        expect_out(5'h02);
        pin_fault = 1'b0;
        step(5);
        expect_out(5'h01);
        $display("faults done");
        step(2);
        complete_run();
    end
endmodule
